//--- ftl_defines.vh
// constants for the flash/torch led mode control block
// What this block does
// - flash enable rising edge starts flash
// - flash ends when pin low, register cleared
// - torch enable rising edge starts torch
// - torch ends when pin low, register cleared
// - inhibit high drops flash to torch level
// - inhibit also applies to register-started flash
// - flash register write starts flash, time-out bounded
// - flash current is max times percentage code
// - flash current off after safety time-out
// - torch register write starts torch while set
// - torch current is max times percentage code
// - overvoltage turns the device off
// - both channels open: off, retry 100 ms
// - short while on: off, retry 100 ms
// - one floating channel: other keeps running
// - host drives bus, device drives acknowledge
// - bus address 0xB4 write, 0xB5 read
// - register address uses low three bits
// - three 8-bit registers at 00h to 02h
// - registers default only at power-on reset
// - bus runs up to 3.4 MHz
// - enable pin high standby; off after 1s low
// - chip-on bit acts as enable pin
// - inhibit bit acts as inhibit pin
`ifndef FTL_DEFINES_VH
`define FTL_DEFINES_VH
`define FTL_DEV_ADDR       7'h5A
`define FTL_REG_MASTER     3'h0
`define FTL_REG_FLASH      3'h1
`define FTL_REG_TORCH      3'h2
`define FTL_MASTER_RST     8'h00
`define FTL_FLASH_RST      8'hE0
`define FTL_TORCH_RST      8'h00
`define FTL_BIT_ON         3
`define FTL_BIT_SHT        2
`define FTL_BIT_OPEN       1
`define FTL_BIT_TSD        0
`define FTL_BIT_FEN        4
`define FTL_BIT_FI         5
`define FTL_BIT_TEN        4
`define FTL_CLK_MHZ        125
`define FTL_RETRY_MS       100
`define FTL_RETRY_CYC      (`FTL_RETRY_MS * 1000 * `FTL_CLK_MHZ)
`define FTL_SHDN_MS        1000
`define FTL_SHDN_CYC       (`FTL_SHDN_MS * 1000 * `FTL_CLK_MHZ)
`define FTL_TMR_STEP_US    156250
`define FTL_TMR_STEP_CYC   (`FTL_TMR_STEP_US * `FTL_CLK_MHZ)
`endif

//--- ftl_sync.v
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module ftl_sync #(
	parameter W = 1 // vector width
) (
	input  wire         clk_i,    // block clock
	input  wire         resetn_i, // async reset, active low
	input  wire [W-1:0] d_i,      // asynchronous input
	output wire [W-1:0] q_o       // synchronised output
);
	reg [W-1:0] s1_q; // first stage, read only by s2
	reg [W-1:0] s2_q; // second stage
	// plain two-stage chain
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
		end
		else
		begin
			s1_q <= d_i;
			s2_q <= s1_q;
		end
	end
	assign q_o = s2_q;
endmodule // ftl_sync

//--- ftl_i2c.v
// i2c slave front end: byte framing, address match, register port
`timescale 1ns/10ps
`include "ftl_defines.vh"
module ftl_i2c (
	input  wire       clk_i,     // block clock
	input  wire       resetn_i,  // async reset, active low
	input  wire       scl_i,     // synchronised scl
	input  wire       sda_i,     // synchronised sda
	output reg        sda_oe_o,  // pull sda low when high
	output reg        wr_o,      // one-cycle register write
	output reg  [2:0] addr_o,    // register index
	output reg  [7:0] wdata_o,   // write data
	input  wire [7:0] rdata_i    // read data at addr_o
);
	localparam ST_IDLE = 3'd0; // wait for start
	localparam ST_DEV  = 3'd1; // device address byte
	localparam ST_REG  = 3'd2; // register address byte
	localparam ST_WDAT = 3'd3; // write data bytes
	localparam ST_RDAT = 3'd4; // read data bytes
	localparam ST_MACK = 3'd5; // host acknowledge after read
	localparam ST_SACK = 3'd6; // our acknowledge slot
	reg [2:0] st_q;     // framing state
	reg [2:0] nxt_q;    // state after the ack slot
	reg [2:0] cnt_q;    // bit counter
	reg [7:0] sh_q;     // shift register
	reg       scl_q;    // scl delayed for edges
	reg       sda_q;    // sda delayed for edges
	reg       rd_q;     // direction of this transfer
	wire scl_rise = scl_i & ~scl_q;
	wire scl_fall = ~scl_i & scl_q;
	wire start    = scl_i & scl_q & sda_q & ~sda_i;
	wire stop     = scl_i & scl_q & ~sda_q & sda_i;
	wire [7:0] sh_n = {sh_q[6:0], sda_i};
	// edge memory
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end
	// byte engine; sampling on the 125 MHz clock keeps up with 3.4 MHz scl
	// fast clock oversampling
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_q     <= ST_IDLE;
			nxt_q    <= ST_IDLE;
			cnt_q    <= 3'd0;
			sh_q     <= 8'h00;
			rd_q     <= 1'b0;
			sda_oe_o <= 1'b0;
			wr_o     <= 1'b0;
			addr_o   <= 3'd0;
			wdata_o  <= 8'h00;
		end
		else
		begin
			wr_o <= 1'b0;
			if (start)
			begin
				// start or repeated start; clear the shifter, since bits left from a
				// refused frame or from the restart clock would be taken as an address
				st_q     <= ST_DEV;
				cnt_q    <= 3'd0;
				sh_q     <= 8'h00;
				sda_oe_o <= 1'b0;
			end
			else if (stop)
			begin
				st_q     <= ST_IDLE;
				sda_oe_o <= 1'b0;
			end
			else
			begin
				case (st_q)
				ST_DEV, ST_REG, ST_WDAT:
				begin
					if (scl_rise)
					begin
						sh_q  <= sh_n;
						cnt_q <= cnt_q + 3'd1;
					end
					if (scl_fall && cnt_q == 3'd0 && sh_q != 8'h00 && st_q == ST_DEV)
					begin
						if (sh_q[7:1] == `FTL_DEV_ADDR)
						begin
							rd_q     <= sh_q[0];
							nxt_q    <= sh_q[0] ? ST_RDAT : ST_REG;
							st_q     <= ST_SACK;
							sda_oe_o <= 1'b1;
						end
						else
							st_q <= ST_IDLE;
					end
					else if (scl_fall && cnt_q == 3'd0 && st_q == ST_REG)
					begin
						addr_o   <= sh_q[2:0];
						nxt_q    <= ST_WDAT;
						st_q     <= ST_SACK;
						sda_oe_o <= 1'b1;
					end
					else if (scl_fall && cnt_q == 3'd0 && st_q == ST_WDAT)
					begin
						wdata_o  <= sh_q;
						wr_o     <= 1'b1;
						nxt_q    <= ST_WDAT;
						st_q     <= ST_SACK;
						sda_oe_o <= 1'b1;
					end
				end
				ST_SACK:
				begin
					if (scl_fall)
					begin
						st_q  <= nxt_q;
						cnt_q <= 3'd0;
						sh_q  <= 8'h00;
						if (nxt_q == ST_RDAT)
							sda_oe_o <= ~rdata_i[7];
						else
							sda_oe_o <= 1'b0;
						if (nxt_q == ST_WDAT && rd_q == 1'b0 && sh_q == 8'h00)
							sh_q <= 8'h00;
					end
				end
				ST_RDAT:
				begin
					// read from the address set earlier
					if (scl_fall)
					begin
						cnt_q <= cnt_q + 3'd1;
						if (cnt_q == 3'd7)
						begin
							sda_oe_o <= 1'b0;
							st_q     <= ST_MACK;
						end
						else
							sda_oe_o <= ~rdata_i[3'd6 - cnt_q];
					end
				end
				ST_MACK:
				begin
					// host nack ends the read
					if (scl_rise)
						st_q <= sda_i ? ST_IDLE : ST_SACK;
					if (scl_rise)
						nxt_q <= ST_RDAT;
				end
				default:
					st_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // ftl_i2c

//--- ftl_top.v
// flash/torch led mode control with register file and fault handling
`timescale 1ns/10ps
`include "ftl_defines.vh"
module ftl_top #(
	parameter RETRY_CYC = `FTL_RETRY_CYC,   // fault retry wait
	parameter SHDN_CYC  = `FTL_SHDN_CYC,    // enable-low shutdown wait
	parameter STEP_CYC  = `FTL_TMR_STEP_CYC // one time-out step
) (
	input  wire       clk_i,              // 125 MHz clock
	input  wire       resetn_i,           // power-on reset, active low
	input  wire       chip_enable_pin_i,  // chip enable pin
	input  wire       flash_enable_pin_i, // flash enable pin
	input  wire       torch_enable_pin_i, // torch enable pin
	input  wire       flash_inhibit_i,    // flash inhibit pin
	input  wire       overvoltage_protect_i, // output over threshold
	input  wire       open_led_detector_i,   // both channels open
	input  wire       led_short_i,        // a channel shorted
	input  wire       thermal_shdn_i,     // junction over temperature
	input  wire       chan_one_open_i,    // channel one floating
	input  wire       chan_two_open_i,    // channel two floating
	input  wire       scl_i,              // i2c clock
	input  wire       sda_i,              // i2c data in
	output reg        sda_oe_o,           // i2c data pulled low
	output reg        sda_o,              // i2c data out level
	output reg        standby_o,          // device enabled
	output reg        boost_on_o,         // boost and regulator on
	output reg        flash_level_o,      // flash-level current
	output reg        torch_level_o,      // torch-level current
	output reg  [3:0] current_code_o,     // percentage code in use
	output reg        channel_one_sink_o, // channel one sink on
	output reg        channel_two_sink_o  // channel two sink on
);
	wire [11:0] raw = {scl_i, sda_i, chip_enable_pin_i, flash_enable_pin_i, torch_enable_pin_i,
		flash_inhibit_i, overvoltage_protect_i, open_led_detector_i, led_short_i, thermal_shdn_i,
		chan_one_open_i, chan_two_open_i};
	wire [11:0] syn; // all pins after two flops
	wire scl_s = syn[11];
	wire sda_s = syn[10];
	wire en_s  = syn[9];
	wire fen_s = syn[8];
	wire ten_s = syn[7];
	wire fi_s  = syn[6];
	wire ovp_s = syn[5];
	wire opn_s = syn[4];
	wire sht_s = syn[3];
	wire tsd_s = syn[2];
	wire c1o_s = syn[1];
	wire c2o_s = syn[0];

	ftl_sync #(.W(12)) u_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.d_i      (raw),
		.q_o      (syn)
	);

	wire       wr;     // register write strobe
	wire [2:0] addr;   // register index
	wire [7:0] wdata;  // write data
	reg  [7:0] rdata;  // read mux
	wire       oe_i2c; // slave pulls sda

	ftl_i2c u_i2c (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.scl_i    (scl_s),
		.sda_i    (sda_s),
		.sda_oe_o (oe_i2c),
		.wr_o     (wr),
		.addr_o   (addr),
		.wdata_o  (wdata),
		.rdata_i  (rdata)
	);

	reg        on_q;      // chip-on bit
	reg        sht_q;     // short status
	reg        opn_q;     // open status
	reg  [7:0] flash_q;   // flash control register
	reg  [7:0] torch_q;   // torch control register
	reg        fen_q;     // flash pin delayed
	reg        ten_q;     // torch pin delayed
	reg        fl_act_q;  // flash mode active
	reg        tr_act_q;  // torch mode active
	reg        fl_to_q;   // flash timed out
	reg [31:0] fl_cnt_q;  // flash time-out counter
	reg        fault_q;   // waiting out a fault
	reg [31:0] flt_cnt_q; // retry counter
	reg        stby_q;    // enabled
	reg [31:0] shdn_cnt_q; // enable-low counter

	// register index match, shared by the write strobes and the read mux
	function sel_reg;
		input [2:0] idx; // index from the bus
		input [2:0] sel; // register of interest
		begin
			sel_reg = (idx == sel);
		end
	endfunction

	wire       ms_wr = wr && sel_reg(addr, `FTL_REG_MASTER); // master write
	wire       fl_wr = wr && sel_reg(addr, `FTL_REG_FLASH);  // flash write
	wire       tr_wr = wr && sel_reg(addr, `FTL_REG_TORCH);  // torch write

	// read mux; reserved bits read zero
	always @*
	begin
		if (sel_reg(addr, `FTL_REG_MASTER))
			rdata = {4'h0, on_q, sht_q, opn_q, tsd_s};
		else if (sel_reg(addr, `FTL_REG_FLASH))
			rdata = flash_q;
		else if (sel_reg(addr, `FTL_REG_TORCH))
			rdata = {2'b00, torch_q[5:0]};
		else
			rdata = 8'h00;
	end

	// register file, set to defaults only by power-on reset
	// three registers, defaults at reset only
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			on_q    <= 1'b0;
			flash_q <= `FTL_FLASH_RST;
			torch_q <= `FTL_TORCH_RST;
		end
		else
		begin
			if (ms_wr)
				on_q <= wdata[`FTL_BIT_ON];
			if (fl_wr)
				flash_q <= wdata;
			if (tr_wr)
				torch_q <= {2'b00, wdata[5:0]};
		end
	end

	// standby and shutdown from enable pin or chip-on bit
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			stby_q     <= 1'b0;
			shdn_cnt_q <= 32'd0;
		end
		else
		begin
			// standby now, shutdown after 1 s low
			if (en_s || on_q)
			begin
				stby_q     <= 1'b1;
				shdn_cnt_q <= 32'd0;
			end
			else if (shdn_cnt_q >= SHDN_CYC)
				stby_q <= 1'b0;
			else
				shdn_cnt_q <= shdn_cnt_q + 32'd1;
		end
	end

	// flash and torch mode state
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			fen_q    <= 1'b0;
			ten_q    <= 1'b0;
			fl_act_q <= 1'b0;
			tr_act_q <= 1'b0;
		end
		else
		begin
			fen_q <= fen_s;
			ten_q <= ten_s;
			if ((fen_s && !fen_q) || (fl_wr && wdata[`FTL_BIT_FEN]))
				fl_act_q <= 1'b1;
			// pin low and register bit cleared
			else if (!fen_s && !flash_q[`FTL_BIT_FEN])
				fl_act_q <= 1'b0;
			if ((ten_s && !ten_q) || (tr_wr && wdata[`FTL_BIT_TEN]))
				tr_act_q <= 1'b1;
			// pin low and register bit cleared
			else if (!ten_s && !torch_q[`FTL_BIT_TEN])
				tr_act_q <= 1'b0;
		end
	end

	// flash safety timer, one step per code value plus one
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			fl_cnt_q <= 32'd0;
			fl_to_q  <= 1'b0;
		end
		else if (!fl_act_q)
		begin
			fl_cnt_q <= 32'd0;
			fl_to_q  <= 1'b0;
		end
		else if (fl_cnt_q >= (flash_q[7:5] + 32'd1) * STEP_CYC)
			fl_to_q <= 1'b1;
		else
			fl_cnt_q <= fl_cnt_q + 32'd1;
	end

	// fault handling with timed retry
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			fault_q   <= 1'b0;
			flt_cnt_q <= 32'd0;
			sht_q     <= 1'b0;
			opn_q     <= 1'b0;
		end
		else if (fault_q)
		begin
			if (flt_cnt_q >= RETRY_CYC)
				fault_q <= 1'b0;
			else
				flt_cnt_q <= flt_cnt_q + 32'd1;
		end
		// open both, short, only while on
		else if (boost_on_o && (opn_s || sht_s))
		begin
			fault_q   <= 1'b1;
			flt_cnt_q <= 32'd0;
			sht_q     <= sht_s;
			opn_q     <= opn_s;
		end
	end

	// output stage, all registered
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			standby_o          <= 1'b0;
			boost_on_o         <= 1'b0;
			flash_level_o      <= 1'b0;
			torch_level_o      <= 1'b0;
			current_code_o     <= 4'h0;
			channel_one_sink_o <= 1'b0;
			channel_two_sink_o <= 1'b0;
			sda_oe_o           <= 1'b0;
			sda_o              <= 1'b0;
		end
		else
		begin
			standby_o <= stby_q;
			// open-drain: drive low only
			sda_oe_o  <= oe_i2c;
			sda_o     <= 1'b0;
			if (!stby_q || fault_q || ovp_s || tsd_s)
			begin
				boost_on_o         <= 1'b0;
				flash_level_o      <= 1'b0;
				torch_level_o      <= 1'b0;
				channel_one_sink_o <= 1'b0;
				channel_two_sink_o <= 1'b0;
			end
			else if (fl_act_q && !fl_to_q)
			begin
				boost_on_o <= 1'b1;
				if (fi_s || torch_q[`FTL_BIT_FI])
				begin
					flash_level_o  <= 1'b0;
					torch_level_o  <= 1'b1;
					current_code_o <= torch_q[3:0];
				end
				else
				begin
					flash_level_o  <= 1'b1;
					torch_level_o  <= 1'b0;
					current_code_o <= flash_q[3:0];
				end
				channel_one_sink_o <= !c1o_s;
				channel_two_sink_o <= !c2o_s;
			end
			else if (tr_act_q)
			begin
				boost_on_o         <= 1'b1;
				flash_level_o      <= 1'b0;
				torch_level_o      <= 1'b1;
				current_code_o     <= torch_q[3:0];
				channel_one_sink_o <= !c1o_s;
				channel_two_sink_o <= !c2o_s;
			end
			else
			begin
				boost_on_o         <= 1'b0;
				flash_level_o      <= 1'b0;
				torch_level_o      <= 1'b0;
				channel_one_sink_o <= 1'b0;
				channel_two_sink_o <= 1'b0;
			end
		end
	end
endmodule // ftl_top

//--- ftl_top_checker.sv
// concurrent checks on the ports of the flash/torch mode control top
`timescale 1ns/10ps
module ftl_top_checker #(
	parameter RETRY_CYC = 200, // fault retry wait
	parameter SHDN_CYC  = 300, // shutdown wait
	parameter STEP_CYC  = 100  // one time-out step
) (
	input wire       clk_i,                 // block clock
	input wire       resetn_i,              // async reset, active low
	input wire       chip_enable_pin_i,     // chip enable pin
	input wire       flash_enable_pin_i,    // flash enable pin
	input wire       flash_inhibit_i,       // inhibit pin
	input wire       overvoltage_protect_i, // over threshold
	input wire       open_led_detector_i,   // both open
	input wire       led_short_i,           // a channel shorted
	input wire       thermal_shdn_i,        // over temperature
	input wire       chan_one_open_i,       // channel one floating
	input wire       chan_two_open_i,       // channel two floating
	input wire       sda_o,                 // open-drain level
	input wire       standby_o,             // device enabled
	input wire       boost_on_o,            // boost on
	input wire       flash_level_o,         // flash level
	input wire       torch_level_o,         // torch level
	input wire       channel_two_sink_o     // channel two sink on
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// run length of flash-level current; the longest legal run is eight steps
	reg [11:0] fl_run_q;
	always @(posedge clk_i or negedge resetn_i)
		if (!resetn_i)
			fl_run_q <= 12'h000;
		else
			fl_run_q <= flash_level_o ? fl_run_q + 12'h001 : 12'h000;
	property p_flash_rise;
		$rose(flash_enable_pin_i) && standby_o && !led_short_i && !open_led_detector_i && !overvoltage_protect_i
			&& !thermal_shdn_i |-> ##[3:8] (flash_level_o || torch_level_o);
	endproperty
	a_flash_rise: assert property (p_flash_rise) else $error("flash edge gave no current");
	property p_inhibit; flash_inhibit_i [*6] |-> !flash_level_o; endproperty
	a_inhibit: assert property (p_inhibit) else $error("flash level kept under inhibit");
	property p_timeout; fl_run_q <= 8 * STEP_CYC + 16; endproperty
	a_timeout: assert property (p_timeout) else $error("flash outlived its time-out");
	property p_ovp; overvoltage_protect_i [*6] |-> !boost_on_o; endproperty
	a_ovp: assert property (p_ovp) else $error("boost on while over threshold");
	property p_open; $rose(open_led_detector_i) && boost_on_o |-> ##[2:6] !boost_on_o; endproperty
	a_open: assert property (p_open) else $error("open leds did not stop boost");
	property p_short; $rose(led_short_i) && boost_on_o |-> ##[2:6] !boost_on_o; endproperty
	a_short: assert property (p_short) else $error("short did not stop boost");
	property p_hold; $fell(boost_on_o) && (led_short_i || open_led_detector_i) |-> !boost_on_o [*8]; endproperty
	a_hold: assert property (p_hold) else $error("retry came too early");
	property p_float;
		(chan_one_open_i && !chan_two_open_i) [*6] ##0 (torch_level_o && boost_on_o) |-> channel_two_sink_o;
	endproperty
	a_float: assert property (p_float) else $error("good channel stopped");
	property p_standby; chip_enable_pin_i [*6] |-> standby_o; endproperty
	a_standby: assert property (p_standby) else $error("enable pin gave no standby");
	property p_sda; !sda_o; endproperty
	a_sda: assert property (p_sda) else $error("sda driven high");
	c_inhibit: cover property (flash_level_o ##1 flash_inhibit_i);
	c_fault: cover property ($fell(boost_on_o));
	c_torch: cover property ($rose(torch_level_o));
endmodule // ftl_top_checker
bind ftl_top ftl_top_checker #(.RETRY_CYC(RETRY_CYC), .SHDN_CYC(SHDN_CYC), .STEP_CYC(STEP_CYC)) u_chk (
	.clk_i(clk_i), .resetn_i(resetn_i), .chip_enable_pin_i(chip_enable_pin_i),
	.flash_enable_pin_i(flash_enable_pin_i), .flash_inhibit_i(flash_inhibit_i),
	.overvoltage_protect_i(overvoltage_protect_i), .open_led_detector_i(open_led_detector_i),
	.led_short_i(led_short_i), .thermal_shdn_i(thermal_shdn_i), .chan_one_open_i(chan_one_open_i),
	.chan_two_open_i(chan_two_open_i), .sda_o(sda_o), .standby_o(standby_o), .boost_on_o(boost_on_o),
	.flash_level_o(flash_level_o), .torch_level_o(torch_level_o), .channel_two_sink_o(channel_two_sink_o));

//--- ftl_host_model.sv
// i2c host model; scl idles high between frames, 8 clocks a bit
`timescale 1ns/10ps
module ftl_host_model (
	input  wire clk_i,    // bench clock, paces the bit timing
	input  wire sda_i,    // resolved sda wire, pulled up
	output reg  scl_o,    // serial clock
	output reg  sda_low_o // pull sda low when high
);
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// one quarter bit, 16 ns
	task q;
		repeat (2) @(negedge clk_i);
	endtask
	// start, also used as repeated start from scl low
	task start;
		q; sda_low_o = 1'b0; q; scl_o = 1'b1; q; sda_low_o = 1'b1; q; scl_o = 1'b0;
	endtask
	task stop;
		q; sda_low_o = 1'b1; q; scl_o = 1'b1; q; sda_low_o = 1'b0; q;
	endtask
	// nine bits, msb first; sda changes only while scl is low
	// host drives all but acknowledge
	task xfer(input [7:0] d, output [7:0] r, output ak);
		integer i;
		for (i = 8; i >= 0; i = i - 1)
		begin
			q; sda_low_o = (i > 0) ? !d[i-1] : 1'b0;
			q; scl_o = 1'b1;
			q; if (i > 0) r[i-1] = sda_i; else ak = sda_i;
			q; scl_o = 1'b0;
		end
	endtask
	task wr(input [7:0] dv, input [7:0] ra, input [7:0] d, output ak);
		reg [7:0] r;
		reg a0, a1, a2;
		start; xfer(dv, r, a0); xfer(ra, r, a1); xfer(d, r, a2); stop;
		ak = a0 | a1 | a2;
	endtask
	task rd(input [7:0] ra, output [7:0] d);
		reg [7:0] r;
		reg a;
		start; xfer(8'hB4, r, a); xfer(ra, r, a); start; xfer(8'hB5, r, a); xfer(8'hFF, d, a); stop;
	endtask
endmodule // ftl_host_model

//--- ftl_top_tb.sv
// self-checking bench for the flash/torch mode control top
`timescale 1ns/10ps
module ftl_top_tb;
	localparam RETRY = 200, SHDN = 300, STEP = 100;
	reg        clk_i = 1'b0, resetn_i = 1'b0, cen = 1'b0, flash_enable_pin = 1'b0, torch_enable_pin = 1'b0, fin = 1'b0;
	reg        overvoltage_protect = 1'b0, opn = 1'b0, sht = 1'b0, ch1o = 1'b0, tsd = 1'b0, ch2o = 1'b0;
	wire       scl, sda_low, sda_oe_o, standby_o, boost_on_o, flash_level_o, torch_level_o, sink1, sink2;
	wire [3:0] current_code_o;
	wire       sda = ~(sda_low | sda_oe_o); // pulled-up open-drain wire
	integer    miscompares = 0, checks_done = 0, k;
	reg  [7:0] d, fc, tc;
	reg        ak;
	always #4 clk_i = ~clk_i;
	ftl_host_model host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	ftl_top #(.RETRY_CYC(RETRY), .SHDN_CYC(SHDN), .STEP_CYC(STEP)) uut (
		.clk_i(clk_i), .resetn_i(resetn_i), .chip_enable_pin_i(cen), .flash_enable_pin_i(flash_enable_pin),
		.torch_enable_pin_i(torch_enable_pin), .flash_inhibit_i(fin), .overvoltage_protect_i(overvoltage_protect), .open_led_detector_i(opn),
		.led_short_i(sht), .thermal_shdn_i(tsd), .chan_one_open_i(ch1o), .chan_two_open_i(ch2o), .scl_i(scl),
		.sda_i(sda), .sda_oe_o(sda_oe_o), .sda_o(), .standby_o(standby_o), .boost_on_o(boost_on_o),
		.flash_level_o(flash_level_o), .torch_level_o(torch_level_o), .current_code_o(current_code_o),
		.channel_one_sink_o(sink1), .channel_two_sink_o(sink2));
	// power-on register contents, unmapped places read zero
	function [7:0] def_val(input [2:0] a);
		def_val = (a == 3'h1) ? 8'hE0 : 8'h00;
	endfunction
	// flash time-out in clocks from the timer field
	function integer flash_to(input [7:0] r);
		flash_to = (r[7:5] + 1) * STEP;
	endfunction
	task cyc(input integer n);
		repeat (n) @(negedge clk_i);
	endtask
	task chk(input [7:0] seen, input [7:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog, about four times the expected run
	initial
	begin
		#200000;
		miscompares = miscompares + 1;
		test_done;
	end
	initial
	begin
		k = $urandom(91);
		cyc(20);
		resetn_i = 1'b1;
		cyc(4);
		for (k = 0; k < 4; k = k + 1)
		begin
			host.rd(k, d);
			chk(d, def_val(k));
		end
		host.rd(8'h09, d);
		chk(d, def_val(1));
		host.wr(8'hB6, 8'h00, 8'h08, ak);
		chk(ak, 1'b1);
		host.wr(8'hB4, 8'h00, 8'h08, ak);
		chk(ak, 1'b0);
		cyc(8);
		chk(standby_o, 1'b1);
		host.rd(8'h00, d);
		chk(d, 8'h08);
		cen = 1'b1;
		fc = $urandom % 16;
		tc = $urandom % 16;
		host.wr(8'hB4, 8'h01, fc, ak);
		flash_enable_pin = 1'b1;
		cyc(8);
		chk(flash_level_o, 1'b1);
		chk(current_code_o, fc);
		fin = 1'b1;
		cyc(8);
		chk({flash_level_o, torch_level_o}, 2'b01);
		fin = 1'b0;
		cyc(8);
		chk(flash_level_o, 1'b1);
		cyc(flash_to(fc) - 10);
		chk(flash_level_o, 1'b0);
		flash_enable_pin = 1'b0;
		host.wr(8'hB4, 8'h01, 8'hF0, ak);
		cyc(4);
		chk(flash_level_o, 1'b1);
		host.wr(8'hB4, 8'h02, {4'h2, tc[3:0]}, ak);
		cyc(8);
		chk({flash_level_o, torch_level_o}, 2'b01);
		host.wr(8'hB4, 8'h02, 8'h00, ak);
		cyc(8);
		chk(flash_level_o, 1'b1);
		fin = 1'b1;
		cyc(8);
		chk({flash_level_o, torch_level_o}, 2'b01);
		fin = 1'b0;
		host.wr(8'hB4, 8'h01, 8'h00, ak);
		cyc(8);
		chk(flash_level_o, 1'b0);
		host.wr(8'hB4, 8'h02, {4'h1, tc[3:0]}, ak);
		cyc(8);
		chk(torch_level_o, 1'b1);
		chk(current_code_o, tc);
		host.rd(8'h02, d);
		chk(d, {4'h1, tc[3:0]});
		host.wr(8'hB4, 8'h02, 8'h00, ak);
		cyc(8);
		chk(torch_level_o, 1'b0);
		torch_enable_pin = 1'b1;
		cyc(8);
		chk(torch_level_o, 1'b1);
		chk({sink1, sink2}, 2'b11);
		flash_enable_pin = 1'b1;
		cyc(8);
		chk({flash_level_o, torch_level_o}, 2'b10);
		flash_enable_pin = 1'b0;
		cyc(8);
		chk({flash_level_o, torch_level_o}, 2'b01);
		ch1o = 1'b1;
		cyc(8);
		chk({sink1, sink2}, 2'b01);
		ch1o = 1'b0;
		cyc(8);
		// short first, then both-open, each with a timed retry
		for (k = 0; k < 2; k = k + 1)
		begin
			{sht, opn} = k ? 2'b01 : 2'b10;
			cyc(10);
			chk(boost_on_o, 1'b0);
			{sht, opn} = 2'b00;
			cyc(RETRY - 30);
			chk(boost_on_o, 1'b0);
			cyc(40);
			chk(boost_on_o, 1'b1);
		end
		overvoltage_protect = 1'b1;
		cyc(10);
		chk(boost_on_o, 1'b0);
		overvoltage_protect = 1'b0;
		torch_enable_pin = 1'b0;
		cen = 1'b0;
		host.wr(8'hB4, 8'h00, 8'h00, ak);
		cyc(SHDN - 50);
		chk(standby_o, 1'b1);
		cyc(80);
		chk(standby_o, 1'b0);
		host.rd(8'h01, d);
		chk(d, 8'h00);
		test_done;
	end
endmodule // ftl_top_tb
